// ==== rtl/sfcd_map.svh ====
/*
 serial flash command decode: opcodes, counts and address constants.
 assumes inclusion by the design modules sfcd_op_decode and sfcd_read_front.
*/
// Contract
// - fast read 1Bh: three address bytes, two dummy bytes, then data.
// - read 0Bh: three address bytes, one dummy byte, then data.
// - slow read 03h: no dummy byte; host keeps clock at or below 50 MHz.
// - read address counter advances by itself per byte streamed.
// - after top location address wraps to zero without delay.
// - read data shifts out on serial output, msb first.
// - chip select release ends read and floats output, even mid byte.
// - erases 20h 52h D8h take address; 60h C7h B0h D0h opcode only.
// - program 02h: three address bytes, no dummy, 1 to 256 data bytes; code passes on data bytes until select rises, with no count limit.
// - dual program A2h is its own program class with address and data.
// - protection register read 3Ch: address then returned data bytes.
// - lockdown 33h and freeze 34h: address then exactly one data byte.
// - lockdown register read 35h: address, no dummy, returned data.
// - security area program 9Bh: address then host data bytes.
// - security area read 77h: address, two dummy bytes, returned data.
// - status byte one write 01h: no address, exactly one data byte.
// - status byte two write 31h: no address, exactly one data byte.
// - id read 9Fh: no address, one to four returned bytes.
// - power-down B9h and resume ABh are opcode only.
// - unsupported opcode: ignore all input until select toggles.
// - select released before opcode and address: nothing done, idle.
// - input sampled on rising serial clock, output changes on falling.
// - address is three bytes; top address bit ignored.
`ifndef SFCD_MAP_SVH
`define SFCD_MAP_SVH

`define SFCD_OP_READ_FAST  8'h1B
`define SFCD_OP_READ       8'h0B
`define SFCD_OP_READ_SLOW  8'h03
`define SFCD_OP_READ_DUAL  8'h3B
`define SFCD_OP_ERASE_4K   8'h20
`define SFCD_OP_ERASE_32K  8'h52
`define SFCD_OP_ERASE_64K  8'hD8
`define SFCD_OP_ERASE_CHA  8'h60
`define SFCD_OP_ERASE_CHB  8'hC7
`define SFCD_OP_PROG       8'h02
`define SFCD_OP_PROG_DUAL  8'hA2
`define SFCD_OP_SUSPEND    8'hB0
`define SFCD_OP_RESUME     8'hD0
`define SFCD_OP_WREN       8'h06
`define SFCD_OP_WRDIS      8'h04
`define SFCD_OP_PROT       8'h36
`define SFCD_OP_UNPROT     8'h39
`define SFCD_OP_RD_PROT    8'h3C
`define SFCD_OP_LOCK       8'h33
`define SFCD_OP_FREEZE     8'h34
`define SFCD_OP_RD_LOCK    8'h35
`define SFCD_OP_OTP_PROG   8'h9B
`define SFCD_OP_OTP_READ   8'h77
`define SFCD_OP_RD_STAT    8'h05
`define SFCD_OP_WR_STAT1   8'h01
`define SFCD_OP_WR_STAT2   8'h31
`define SFCD_OP_SOFT_RST   8'hF0
`define SFCD_OP_ID         8'h9F
`define SFCD_OP_PWR_DOWN   8'hB9
`define SFCD_OP_PWR_UP     8'hAB

`define SFCD_ADDR_BYTES    2'h3
`define SFCD_ADDR_TOP      23'h7FFFFF
`define SFCD_ADDR_ZERO     23'h000000
`define SFCD_ADDR_W        23
`define SFCD_ID_MAX        3'h4

`endif

// ==== rtl/sfcd_pkg.sv ====
/*
 serial flash command decode: shared types.
 assumes nothing beyond the tool's package support.
*/
package sfcd_pkg;

    // command class decoded from the opcode
    typedef enum logic [3:0] {
        CLS_NONE    = 4'h0,
        CLS_READ    = 4'h1,
        CLS_ERASE   = 4'h2,
        CLS_OPONLY  = 4'h3,
        CLS_PROG    = 4'h4,
        CLS_PROG2   = 4'h5,
        CLS_RDREG   = 4'h6,
        CLS_WR1     = 4'h7,
        CLS_WRN     = 4'h8,
        CLS_ID      = 4'h9,
        CLS_RDDUAL  = 4'hA,
        CLS_RDSTAT  = 4'hB
    } sfcd_class_t;

    // decoder phases, one-hot
    typedef enum logic [5:0] {
        ST_OPCODE = 6'h01,
        ST_ADDR   = 6'h02,
        ST_DUMMY  = 6'h04,
        ST_DATAIN = 6'h08,
        ST_OUT    = 6'h10,
        ST_IGNORE = 6'h20
    } sfcd_state_t;

endpackage

// ==== rtl/sfcd_op_decode.sv ====
/*
 serial flash command decode: opcode to class and byte counts.
 assumes a complete opcode byte at its input; purely combinational.
*/
`timescale 1ns/100ps
`include "sfcd_map.svh"

module sfcd_op_decode (
    input  wire logic [7:0]           opcode,
    output sfcd_pkg::sfcd_class_t     opClass,
    output logic                      hasAddr,
    output logic [1:0]                dummyBytes
);

    // ----------------------------------------
    // opcode table
    // ----------------------------------------
    always_comb
    begin
        opClass    = sfcd_pkg::CLS_NONE;
        hasAddr    = 1'b0;
        dummyBytes = 2'h0;
        unique case (opcode)
            `SFCD_OP_READ_FAST:
            begin
                opClass = sfcd_pkg::CLS_READ; hasAddr = 1'b1; dummyBytes = 2'h2;
            end
            `SFCD_OP_READ:
            begin
                opClass = sfcd_pkg::CLS_READ; hasAddr = 1'b1; dummyBytes = 2'h1;
            end
            `SFCD_OP_READ_SLOW:
            begin
                opClass = sfcd_pkg::CLS_READ; hasAddr = 1'b1;
            end
            `SFCD_OP_READ_DUAL:
            begin
                opClass = sfcd_pkg::CLS_RDDUAL; hasAddr = 1'b1; dummyBytes = 2'h1;
            end
            `SFCD_OP_ERASE_4K, `SFCD_OP_ERASE_32K, `SFCD_OP_ERASE_64K,
            `SFCD_OP_PROT, `SFCD_OP_UNPROT:
            begin
                opClass = sfcd_pkg::CLS_ERASE; hasAddr = 1'b1;
            end
            `SFCD_OP_ERASE_CHA, `SFCD_OP_ERASE_CHB, `SFCD_OP_SUSPEND, `SFCD_OP_RESUME,
            `SFCD_OP_WREN, `SFCD_OP_WRDIS, `SFCD_OP_PWR_DOWN, `SFCD_OP_PWR_UP:
                opClass = sfcd_pkg::CLS_OPONLY;
            `SFCD_OP_PROG:
            begin
                opClass = sfcd_pkg::CLS_PROG; hasAddr = 1'b1;
            end
            `SFCD_OP_PROG_DUAL:
            begin
                opClass = sfcd_pkg::CLS_PROG2; hasAddr = 1'b1;
            end
            `SFCD_OP_RD_PROT, `SFCD_OP_RD_LOCK:
            begin
                opClass = sfcd_pkg::CLS_RDREG; hasAddr = 1'b1;
            end
            `SFCD_OP_LOCK, `SFCD_OP_FREEZE:
            begin
                opClass = sfcd_pkg::CLS_WR1; hasAddr = 1'b1;
            end
            `SFCD_OP_OTP_PROG:
            begin
                opClass = sfcd_pkg::CLS_WRN; hasAddr = 1'b1;
            end
            `SFCD_OP_OTP_READ:
            begin
                opClass = sfcd_pkg::CLS_RDREG; hasAddr = 1'b1; dummyBytes = 2'h2;
            end
            `SFCD_OP_WR_STAT1, `SFCD_OP_WR_STAT2, `SFCD_OP_SOFT_RST:
                opClass = sfcd_pkg::CLS_WR1;
            `SFCD_OP_RD_STAT:
                opClass = sfcd_pkg::CLS_RDSTAT;
            `SFCD_OP_ID:
                opClass = sfcd_pkg::CLS_ID;
            default:
                opClass = sfcd_pkg::CLS_NONE;
        endcase
    end

endmodule

// ==== rtl/sfcd_read_front.sv ====
/*
 serial flash command decode and sequential read-array engine.
 assumes serial clock, select and serial input are synchronous to clock;
 array, register and id bytes are supplied combinationally by the core.
*/
`timescale 1ns/100ps
`include "sfcd_map.svh"

module sfcd_read_front (
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic                  sck,
    input  wire logic                  csN,
    input  wire logic                  si,
    input  wire logic [7:0]            memData,
    input  wire logic [7:0]            regData,
    output logic                       so,
    output logic                       soEn,
    output logic [22:0]                memAddr,
    output logic [7:0]                 opcodeOut,
    output logic [3:0]                 cmdClass,
    output logic [23:0]                cmdAddr,
    output logic                       cmdValid,
    output logic [7:0]                 wrData,
    output logic                       wrValid,
    output logic                       cmdAbort
);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [22:0] nextAddr(input logic [22:0] a);
        nextAddr = (a == `SFCD_ADDR_TOP) ? `SFCD_ADDR_ZERO : a + 23'h000001;
    endfunction

    // ----------------------------------------
    // edge detection and byte assembly
    // ----------------------------------------
    logic                     sck_q;
    logic                     csN_q;
    sfcd_pkg::sfcd_state_t    state_q, state_d;
    logic [2:0]               bitCnt_q;
    logic [1:0]               byteCnt_q;
    logic [7:0]               shIn_q;
    logic [7:0]               op_q;
    logic [23:0]              addr_q;
    logic [22:0]              rdAddr_q;
    logic [7:0]               shOut_q;
    logic [2:0]               outBits_q;
    logic [2:0]               idCnt_q;
    logic                     so_q, soEn_q, cmdValid_q, wrValid_q, abort_q;
    logic [7:0]               wrData_q;

    wire                      rise     = sck & ~sck_q;
    wire                      fall     = ~sck & sck_q;
    wire                      selected = ~csN;
    wire                      csRelease = csN & ~csN_q;
    wire [7:0]                byteIn   = {shIn_q[6:0], si};
    wire                      byteDone = rise & (bitCnt_q == 3'h7);

    sfcd_pkg::sfcd_class_t    decClass;
    logic                     decAddr;
    logic [1:0]               decDummy;
    sfcd_pkg::sfcd_class_t    cls_q;
    logic [1:0]               dummy_q;

    sfcd_op_decode u_dec (
        .opcode     (byteIn),
        .opClass    (decClass),
        .hasAddr    (decAddr),
        .dummyBytes (decDummy)
    );

    wire isOutCls = (cls_q == sfcd_pkg::CLS_READ) | (cls_q == sfcd_pkg::CLS_RDREG)
                  | (cls_q == sfcd_pkg::CLS_RDDUAL) | (cls_q == sfcd_pkg::CLS_RDSTAT)
                  | (cls_q == sfcd_pkg::CLS_ID);
    wire isMemCls = (cls_q == sfcd_pkg::CLS_READ) | (cls_q == sfcd_pkg::CLS_RDDUAL);
    wire [7:0] srcByte = isMemCls ? memData : regData;
    wire idEnd = (cls_q == sfcd_pkg::CLS_ID) & (idCnt_q == `SFCD_ID_MAX) & (outBits_q == 3'h0);
    wire [23:0] addrFull = {addr_q[15:0], byteIn};
    wire decIsOut = (decClass == sfcd_pkg::CLS_READ) | (decClass == sfcd_pkg::CLS_RDREG)
                  | (decClass == sfcd_pkg::CLS_RDDUAL) | (decClass == sfcd_pkg::CLS_RDSTAT)
                  | (decClass == sfcd_pkg::CLS_ID);
    wire addrLast = byteDone & (byteCnt_q == 2'h2);
    wire dummyLast = byteDone & (byteCnt_q == dummy_q - 2'h1);

    // ----------------------------------------
    // phase sequencing
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            sfcd_pkg::ST_OPCODE:
                if (byteDone)
                begin
                    if (decClass == sfcd_pkg::CLS_NONE)
                        state_d = sfcd_pkg::ST_IGNORE;
                    else if (decAddr)
                        state_d = sfcd_pkg::ST_ADDR;
                    else if (decIsOut)
                        state_d = sfcd_pkg::ST_OUT;
                    else if (decClass == sfcd_pkg::CLS_OPONLY)
                        state_d = sfcd_pkg::ST_IGNORE;
                    else
                        state_d = sfcd_pkg::ST_DATAIN;
                end
            sfcd_pkg::ST_ADDR:
                if (addrLast)
                begin
                    if (dummy_q != 2'h0)
                        state_d = sfcd_pkg::ST_DUMMY;
                    else if (isOutCls)
                        state_d = sfcd_pkg::ST_OUT;
                    else if (cls_q == sfcd_pkg::CLS_ERASE)
                        state_d = sfcd_pkg::ST_IGNORE;
                    else
                        state_d = sfcd_pkg::ST_DATAIN;
                end
            sfcd_pkg::ST_DUMMY:
                if (dummyLast)
                    state_d = sfcd_pkg::ST_OUT;
            sfcd_pkg::ST_DATAIN:
                if (byteDone & (cls_q == sfcd_pkg::CLS_WR1))
                    state_d = sfcd_pkg::ST_IGNORE;
            sfcd_pkg::ST_OUT:
                if (idEnd)
                    state_d = sfcd_pkg::ST_IGNORE;
            sfcd_pkg::ST_IGNORE:
                state_d = sfcd_pkg::ST_IGNORE;
            default:
                state_d = sfcd_pkg::ST_IGNORE;
        endcase
    end

    // ----------------------------------------
    // input side: rising edge sampling
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (!resetn || !selected)
        begin
            state_q   <= sfcd_pkg::ST_OPCODE;
            bitCnt_q  <= 3'h0;
            byteCnt_q <= 2'h0;
            shIn_q    <= 8'h00;
        end
        else if (rise)
        begin
            state_q  <= state_d;
            shIn_q   <= byteIn;
            bitCnt_q <= bitCnt_q + 3'h1;
            if (byteDone)
                byteCnt_q <= (state_d != state_q) ? 2'h0 : byteCnt_q + 2'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            sck_q   <= 1'b0;
            csN_q   <= 1'b1;
            op_q    <= 8'h00;
            cls_q   <= sfcd_pkg::CLS_NONE;
            dummy_q <= 2'h0;
            addr_q  <= 24'h000000;
        end
        else
        begin
            sck_q <= sck;
            csN_q <= csN;
            if (selected & byteDone & (state_q == sfcd_pkg::ST_OPCODE))
            begin
                op_q    <= byteIn;
                cls_q   <= decClass;
                dummy_q <= decDummy;
            end
            if (selected & byteDone & (state_q == sfcd_pkg::ST_ADDR))
                addr_q <= addrFull;
        end
    end

    // ----------------------------------------
    // command reports to the core
    // ----------------------------------------
    wire opOnlyDone = (state_q == sfcd_pkg::ST_OPCODE) & byteDone & (decClass != sfcd_pkg::CLS_NONE) & ~decAddr;
    wire addrDone   = (state_q == sfcd_pkg::ST_ADDR) & addrLast;
    wire earlyQuit  = csRelease & ((state_q == sfcd_pkg::ST_OPCODE) | (state_q == sfcd_pkg::ST_ADDR));

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cmdValid_q <= 1'b0;
            wrValid_q  <= 1'b0;
            wrData_q   <= 8'h00;
            abort_q    <= 1'b0;
        end
        else
        begin
            cmdValid_q <= selected & (opOnlyDone | addrDone);
            wrValid_q  <= selected & byteDone & (state_q == sfcd_pkg::ST_DATAIN);
            if (selected & byteDone & (state_q == sfcd_pkg::ST_DATAIN))
                wrData_q <= byteIn;
            abort_q    <= earlyQuit;
        end
    end

    // ----------------------------------------
    // output side: falling edge shifting
    // ----------------------------------------
    wire enterOut = rise & (state_q != sfcd_pkg::ST_OUT) & (state_d == sfcd_pkg::ST_OUT);
    wire [22:0] startAddr = (state_q == sfcd_pkg::ST_ADDR) ? addrFull[22:0] : addr_q[22:0];

    always_ff @(posedge clock)
    begin
        if (!resetn || !selected)
        begin
            so_q      <= 1'b0;
            soEn_q    <= 1'b0;
            outBits_q <= 3'h0;
            idCnt_q   <= 3'h0;
            shOut_q   <= 8'h00;
            if (!resetn)
                rdAddr_q <= `SFCD_ADDR_ZERO;
        end
        else
        begin
            if (enterOut)
            begin
                rdAddr_q  <= startAddr;
                outBits_q <= 3'h0;
            end
            else if (fall & (state_q == sfcd_pkg::ST_OUT))
            begin
                soEn_q    <= 1'b1;
                outBits_q <= outBits_q + 3'h1;
                if (outBits_q == 3'h0)
                begin
                    so_q     <= srcByte[7];
                    shOut_q  <= {srcByte[6:0], 1'b0};
                    rdAddr_q <= nextAddr(rdAddr_q);
                    idCnt_q  <= idCnt_q + 3'h1;
                end
                else
                begin
                    so_q    <= shOut_q[7];
                    shOut_q <= {shOut_q[6:0], 1'b0};
                end
            end
            else if (state_q == sfcd_pkg::ST_IGNORE)
                soEn_q <= 1'b0;
        end
    end

    assign so        = so_q;
    assign soEn      = soEn_q;
    assign memAddr   = rdAddr_q;
    assign opcodeOut = op_q;
    assign cmdClass  = cls_q;
    assign cmdAddr   = addr_q;
    assign cmdValid  = cmdValid_q;
    assign wrData    = wrData_q;
    assign wrValid   = wrValid_q;
    assign cmdAbort  = abort_q;

endmodule

// ==== tb/sfcd_properties.sv ====
/*
 checker for the read front: output timing, address counter and pulses.
 assumes binding to sfcd_read_front; ports mirror the design's own.
*/
`timescale 1ns/100ps
module sfcd_properties (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        sck,
    input wire logic        csN,
    input wire logic        si,
    input wire logic [7:0]  memData,
    input wire logic [7:0]  regData,
    input wire logic        so,
    input wire logic        soEn,
    input wire logic [22:0] memAddr,
    input wire logic [7:0]  opcodeOut,
    input wire logic [3:0]  cmdClass,
    input wire logic [23:0] cmdAddr,
    input wire logic        cmdValid,
    input wire logic [7:0]  wrData,
    input wire logic        wrValid,
    input wire logic        cmdAbort
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    select_off_a: assert property (csN |=> !soEn && !so)
        else $error("output active while select high");
    so_edge_a: assert property (!$past(csN) && $changed(so) |-> !$past(sck) && $past(sck, 2))
        else $error("output bit changed off a falling serial edge");
    out_start_a: assert property ($rose(soEn) |-> !csN && !$past(sck) && $past(sck, 2))
        else $error("output enabled off a falling serial edge");
    addr_step_a: assert property (soEn && $past(soEn) && $changed(memAddr) |-> memAddr == $past(memAddr) + 23'h1)
        else $error("read address did not step by one");
    addr_load_a: assert property ($rose(soEn) && cmdClass == sfcd_pkg::CLS_READ |-> memAddr == cmdAddr[22:0] + 23'h1)
        else $error("read address not loaded from collected address");
    abort_time_a: assert property (cmdAbort |-> $past(csN) && !$past(csN, 2) && !cmdValid)
        else $error("abort pulse without select release");
    byte_done_a: assert property (cmdValid || wrValid |-> $past(sck) && !$past(sck, 2))
        else $error("byte pulse off a rising serial edge");
    wr_pulse_a: assert property (wrValid |=> !wrValid [*8])
        else $error("data pulse longer than one cycle");
    known_op_a: assert property (cmdValid |-> cmdClass != sfcd_pkg::CLS_NONE)
        else $error("unsupported opcode reported as command");

    wrap_c: cover property (memAddr == 23'h000000 && $past(memAddr) == 23'h7FFFFF);
    abort_c: cover property (cmdAbort);
    write_c: cover property (wrValid);
    read_c: cover property ($rose(soEn));
endmodule

bind sfcd_read_front sfcd_properties sfcd_properties_inst (
    .clock(clock), .resetn(resetn), .sck(sck), .csN(csN), .si(si), .memData(memData),
    .regData(regData), .so(so), .soEn(soEn), .memAddr(memAddr), .opcodeOut(opcodeOut),
    .cmdClass(cmdClass), .cmdAddr(cmdAddr), .cmdValid(cmdValid), .wrData(wrData),
    .wrValid(wrValid), .cmdAbort(cmdAbort)
);

// ==== tb/sfcd_host_model.sv ====
/*
 host side of the serial link: frames, byte and partial byte shifts.
 assumes tasks are called from the bench; lines change at falling clock.
*/
`timescale 1ns/100ps
module sfcd_host_model (
    input  wire logic clock,
    input  wire logic so,
    input  wire logic soEn,
    output logic      sck,
    output logic      csN,
    output logic      si
);
    // serial clock level between frames: low for mode 0, high for mode 3
    logic idleHigh = 1'b0;
    initial
    begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end

    // select opens every operation; serial clock is four system clocks a bit
    task automatic frameStart();
        @(negedge clock);
        sck <= idleHigh;
        @(negedge clock);
        csN <= 1'b0;
        @(negedge clock);
    endtask

    // drive on falling serial edge, sample on rising edge, msb first
    task automatic shiftBits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            @(negedge clock);
            sck <= 1'b0;
            si <= tx[i];
            @(negedge clock);
            @(negedge clock);
            sck <= 1'b1;
            rx[i] = soEn ? so : ~so;
            @(negedge clock);
        end
    endtask

    task automatic frameEnd();
        @(negedge clock);
        csN <= 1'b1;
        si <= ~si;
        @(negedge clock);
        sck <= idleHigh;
        repeat (2) @(negedge clock);
    endtask
endmodule

// ==== tb/testbench.sv ====
/*
 self-checking bench: reads, command decode, aborts and ignored opcodes.
 assumes the host model drives the serial side and the checker is bound.
*/
`timescale 1ns/100ps
module testbench;
    logic        clock;
    logic        resetn;
    logic [7:0]  regData;
    logic [7:0]  memData;
    wire         sck;
    wire         csN;
    wire         si;
    logic        so;
    logic        soEn;
    logic [22:0] memAddr;
    logic [7:0]  opcodeOut;
    logic [3:0]  cmdClass;
    logic [23:0] cmdAddr;
    logic        cmdValid;
    logic [7:0]  wrData;
    logic        wrValid;
    logic        cmdAbort;
    int          errorCnt = 0;
    int          numChecks = 0;
    int          validCnt = 0;
    int          abortCnt = 0;
    int          enCnt = 0;
    logic [7:0]  wrQ [$];
    logic [7:0]  ops [32] = '{8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'hB0,
        8'hD0, 8'h06, 8'h04, 8'h36, 8'h39, 8'h02, 8'hA2, 8'h3C, 8'h35, 8'h9B, 8'h77, 8'h05,
        8'h01, 8'h31, 8'h9F, 8'hB9, 8'hAB, 8'h33, 8'h34, 8'hF0, 8'h5A, 8'hFF};

    sfcd_read_front sfcd_read_front_inst (
        .clock(clock), .resetn(resetn), .sck(sck), .csN(csN), .si(si), .memData(memData),
        .regData(regData), .so(so), .soEn(soEn), .memAddr(memAddr), .opcodeOut(opcodeOut),
        .cmdClass(cmdClass), .cmdAddr(cmdAddr), .cmdValid(cmdValid), .wrData(wrData),
        .wrValid(wrValid), .cmdAbort(cmdAbort)
    );
    sfcd_host_model sfcd_host_model_inst (.clock(clock), .so(so), .soEn(soEn), .sck(sck), .csN(csN), .si(si));

    function automatic logic [7:0] memByte(input logic [22:0] a);
        return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]} ^ 8'h5A;
    endfunction

    function automatic logic [3:0] expClass(input logic [7:0] op);
        case (op)
            8'h1B, 8'h0B, 8'h03: return sfcd_pkg::CLS_READ;
            8'h20, 8'h52, 8'hD8, 8'h36, 8'h39: return sfcd_pkg::CLS_ERASE;
            8'h60, 8'hC7, 8'hB0, 8'hD0, 8'h06, 8'h04, 8'hB9, 8'hAB: return sfcd_pkg::CLS_OPONLY;
            8'h02: return sfcd_pkg::CLS_PROG;
            8'hA2: return sfcd_pkg::CLS_PROG2;
            8'h3C, 8'h35, 8'h77: return sfcd_pkg::CLS_RDREG;
            8'h9B: return sfcd_pkg::CLS_WRN;
            8'h01, 8'h31, 8'h33, 8'h34, 8'hF0: return sfcd_pkg::CLS_WR1;
            8'h9F: return sfcd_pkg::CLS_ID;
            8'h3B: return sfcd_pkg::CLS_RDDUAL;
            8'h05: return sfcd_pkg::CLS_RDSTAT;
            default: return sfcd_pkg::CLS_NONE;
        endcase
    endfunction

    assign memData = memByte(memAddr);

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(negedge clock)
    begin
        validCnt += (cmdValid === 1'b1);
        abortCnt += (cmdAbort === 1'b1);
        enCnt += (soEn === 1'b1);
        if (wrValid === 1'b1)
            wrQ.push_back(wrData);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic doRead(input logic [7:0] op, input logic [23:0] addr, input int n, input int tail);
        logic [7:0]  rx;
        logic [22:0] a;
        a = addr[22:0];
        sfcd_host_model_inst.frameStart();
        sfcd_host_model_inst.shiftBits(op, 8, rx);
        for (int b = 2; b >= 0; b--)
            sfcd_host_model_inst.shiftBits(addr[b*8 +: 8], 8, rx);
        check(cmdAddr, addr);
        repeat ((op == 8'h1B) ? 2 : (op == 8'h0B) ? 1 : 0) sfcd_host_model_inst.shiftBits(8'($urandom), 8, rx);
        repeat (n)
        begin
            sfcd_host_model_inst.shiftBits(8'($urandom), 8, rx);
            check(rx, memByte(a));
            a = a + 23'h1;
        end
        if (tail > 0)
            sfcd_host_model_inst.shiftBits(8'($urandom), tail, rx);
        sfcd_host_model_inst.frameEnd();
        check(soEn, 1'b0);
    endtask

    task automatic doCmd(input logic [7:0] op);
        logic [7:0] rx;
        logic [7:0] d;
        logic [3:0] cls;
        int         v;
        int         e;
        cls = expClass(op);
        v = validCnt;
        e = enCnt;
        d = 8'($urandom);
        wrQ.delete();
        sfcd_host_model_inst.frameStart();
        sfcd_host_model_inst.shiftBits(op, 8, rx);
        if (cls inside {sfcd_pkg::CLS_READ, sfcd_pkg::CLS_ERASE, sfcd_pkg::CLS_PROG, sfcd_pkg::CLS_PROG2,
            sfcd_pkg::CLS_RDREG, sfcd_pkg::CLS_WRN, sfcd_pkg::CLS_RDDUAL} || op inside {8'h33, 8'h34})
            repeat (3) sfcd_host_model_inst.shiftBits(8'($urandom), 8, rx);
        if (cls != sfcd_pkg::CLS_OPONLY)
            repeat ((cls == sfcd_pkg::CLS_NONE) ? 4 : 1) sfcd_host_model_inst.shiftBits(d, 8, rx);
        sfcd_host_model_inst.frameEnd();
        if (cls == sfcd_pkg::CLS_NONE)
        begin
            check(validCnt - v + enCnt - e + wrQ.size(), 0);
        end
        else
        begin
            check(cmdClass, cls);
            check(opcodeOut, op);
        end
        if (cls inside {sfcd_pkg::CLS_WR1, sfcd_pkg::CLS_PROG, sfcd_pkg::CLS_WRN})
            check({wrQ.size() == 1, (wrQ.size() > 0) ? wrQ[0] : 8'h00}, {1'b1, d});
        if (cls inside {sfcd_pkg::CLS_OPONLY, sfcd_pkg::CLS_ERASE, sfcd_pkg::CLS_PROG, sfcd_pkg::CLS_READ,
            sfcd_pkg::CLS_WR1})
            check(validCnt - v, 1);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clock);
        errorCnt++;
        report_and_stop();
    end

    initial
    begin
        logic [7:0] rx;
        int         v;
        int         a;
        void'($urandom(86699));
        resetn = 1'b0;
        regData = 8'h00;
        repeat (20) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        doRead(8'h03, 24'hFFFFFE, 4, 0);
        doRead(8'h1B, 24'h7FFFFF, 2, 0);
        doRead(8'h0B, 24'h000010, 2, 3);
        repeat (20)
        begin
            sfcd_host_model_inst.idleHigh = 1'($urandom);
            doRead(ops[$urandom % 3], 24'($urandom), 1 + $urandom % 3, $urandom % 2);
        end
        foreach (ops[i])
            doCmd(ops[i]);
        v = validCnt;
        a = abortCnt;
        sfcd_host_model_inst.frameStart();
        sfcd_host_model_inst.shiftBits(8'h0B, 8, rx);
        sfcd_host_model_inst.shiftBits(8'h12, 8, rx);
        sfcd_host_model_inst.shiftBits(8'h34, 3, rx);
        sfcd_host_model_inst.frameEnd();
        check(abortCnt - a, 1);
        check(validCnt - v, 0);
        doRead(8'h0B, 24'h123456, 1, 0);
        regData = 8'($urandom);
        sfcd_host_model_inst.frameStart();
        sfcd_host_model_inst.shiftBits(8'h9F, 8, rx);
        repeat (4)
        begin
            sfcd_host_model_inst.shiftBits(8'($urandom), 8, rx);
            check(rx, regData);
        end
        sfcd_host_model_inst.shiftBits(8'($urandom), 8, rx);
        check(soEn, 1'b0);
        sfcd_host_model_inst.frameEnd();
        report_and_stop();
    end
endmodule
